// [logic/rfsd_pkg.sv]
// constants and types of the rf receiver status display block
`default_nettype none
package rfsd_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CODE_W = 4;
  // register byte offsets
  localparam logic [7:0] OFF_REG_DISP = 8'h2C;
  localparam logic [7:0] OFF_PEAK_DISP = 8'h2D;
  localparam logic [7:0] OFF_GAIN_STATE = 8'h2E;
  localparam logic [7:0] OFF_REG_CTRL = 8'h38;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h39;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h3A;
  // field positions
  localparam int unsigned HI_LSB = 4;
  localparam int unsigned HI_MSB = 7;
  localparam int unsigned LO_MSB = 3;
  localparam int unsigned LIM_BIT = 0;
  localparam int unsigned EXT_SEL_BIT = 7;
  // interrupt status bits
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_ADJ = 0;
  localparam int unsigned IRQ_LIM = 1;
  localparam int unsigned IRQ_PEAK = 2;
  // reset values and codes
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] CODE_ZERO = 4'h0;
  localparam logic [3:0] CODE_MAX = 4'hF;
  localparam logic [IRQ_W-1:0] IRQ_NONE = 3'h0;
  typedef struct packed {
    logic [CODE_W-1:0] amp;
    logic [CODE_W-1:0] phase;
  } rfsd_pair_t;
  typedef enum logic [1:0] {
    RFSD_IDLE,
    RFSD_RD,
    RFSD_WR
  } rfsd_acc_t;
endpackage : rfsd_pkg
`default_nettype wire

// [logic/rfsd_peak_hold.sv]
// peak tracker for one received signal strength channel
`timescale 1ns/1ps
`default_nettype none
module rfsd_peak_hold (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_start,
  input wire logic i_clr,
  input wire logic i_vld,
  input wire logic [rfsd_pkg::CODE_W-1:0] i_code,
  output logic [rfsd_pkg::CODE_W-1:0] o_peak,
  output logic o_raise
);
  logic [rfsd_pkg::CODE_W-1:0] peak_ff;
  logic raise_ff;
  logic higher;

  assign higher = i_vld && (i_code > peak_ff);
  assign o_peak = peak_ff;
  assign o_raise = raise_ff;

  // new reception or clear command wins over a sample in the same cycle
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      peak_ff <= rfsd_pkg::CODE_ZERO;
    end else if (i_start || i_clr) begin
      peak_ff <= rfsd_pkg::CODE_ZERO;
    end else if (higher) begin
      peak_ff <= i_code;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      raise_ff <= 1'b0;
    end else begin
      raise_ff <= higher && !i_start && !i_clr;
    end
  end

  a_peak_restart: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_start || i_clr) |=> peak_ff == rfsd_pkg::CODE_ZERO)
    else $error("peak not cleared on start or clear");
  a_peak_retained: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (!i_start && !i_clr && !higher) |=> $stable(peak_ff))
    else $error("peak changed without a higher sample");
endmodule : rfsd_peak_hold
`default_nettype wire

// [logic/rfsd_gain_sum.sv]
// total second and third stage gain reduction of one channel
`timescale 1ns/1ps
`default_nettype none
module rfsd_gain_sum (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [rfsd_pkg::CODE_W-1:0] i_setting,
  input wire logic [rfsd_pkg::CODE_W-1:0] i_squelch,
  input wire logic [rfsd_pkg::CODE_W-1:0] i_agc,
  output logic [rfsd_pkg::CODE_W-1:0] o_total
);
  logic [rfsd_pkg::CODE_W+1:0] sum;
  logic [rfsd_pkg::CODE_W-1:0] total_ff;

  assign sum = {2'h0, i_setting} + {2'h0, i_squelch} + {2'h0, i_agc};
  assign o_total = total_ff;

  // saturate: the code range tops out, larger cuts cannot be shown
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      total_ff <= rfsd_pkg::CODE_ZERO;
    end else if (sum > {2'h0, rfsd_pkg::CODE_MAX}) begin
      total_ff <= rfsd_pkg::CODE_MAX;
    end else begin
      total_ff <= sum[rfsd_pkg::CODE_W-1:0];
    end
  end

  a_gain_total: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ##1 total_ff == ((($past(sum)) > 6'h0F) ? 4'hF : $past(sum[3:0])))
    else $error("gain total not the saturated sum");
endmodule : rfsd_gain_sum
`default_nettype wire

// [logic/rfsd_top.sv]
// rf receiver status display registers with interrupt and regulator source select
// What this block does
// - the regulator display shows in bits 7:4 the code chosen by the latest regulator adjust.
// - bit 0 of the regulator display reads 1 while the rf supply regulator limits current.
// - bits 7:4 of the peak display hold the amplitude peak until a new reception or a clear.
// - bits 3:0 of the peak display hold the phase peak until a new reception or a clear.
// - bits 7:4 of the gain state show the amplitude gain cut of setting, squelch and agc summed and saturated at 15.
// - bits 3:0 of the gain state show the phase gain cut of setting, squelch and agc summed and saturated at 15.
// - a mode bit selects the regulator code from the adjust result or a written external code.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module rfsd_top (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [rfsd_pkg::ADDR_W-1:0] i_addr,
  input wire logic [rfsd_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [rfsd_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_adj_done,
  input wire logic [rfsd_pkg::CODE_W-1:0] i_adj_code,
  input wire logic i_cur_lim,
  input wire logic i_rx_start,
  input wire logic i_peak_clr,
  input wire logic i_sample_vld,
  input wire rfsd_pkg::rfsd_pair_t i_sample,
  input wire logic [rfsd_pkg::CODE_W-1:0] i_amp_channel_gain_setting,
  input wire logic [rfsd_pkg::CODE_W-1:0] i_phase_channel_gain_setting,
  input wire rfsd_pkg::rfsd_pair_t i_squelch_cut,
  input wire rfsd_pkg::rfsd_pair_t i_agc_cut,
  output logic [rfsd_pkg::CODE_W-1:0] o_reg_code,
  output logic o_irq
);
  function automatic logic hit(input logic [rfsd_pkg::ADDR_W-1:0] addr,
                               input logic [rfsd_pkg::ADDR_W-1:0] off);
    hit = (addr == off);
  endfunction : hit

  rfsd_pkg::rfsd_acc_t acc;
  logic [rfsd_pkg::CODE_W-1:0] adj_code_ff;
  logic lim_meta_ff;
  logic lim_sync_ff;
  logic lim_prev_ff;
  logic [rfsd_pkg::DATA_W-1:0] reg_ctrl_ff;
  logic [rfsd_pkg::IRQ_W-1:0] irq_stat_ff;
  logic [rfsd_pkg::IRQ_W-1:0] irq_mask_ff;
  logic [rfsd_pkg::IRQ_W-1:0] irq_set;
  logic [rfsd_pkg::IRQ_W-1:0] irq_clr;
  logic [rfsd_pkg::DATA_W-1:0] rdata_ff;
  logic [rfsd_pkg::DATA_W-1:0] nxt_rdata;
  logic [rfsd_pkg::CODE_W-1:0] reg_code_ff;
  logic [rfsd_pkg::CODE_W-1:0] nxt_reg_code;
  logic irq_ff;
  rfsd_pkg::rfsd_pair_t peak;
  rfsd_pkg::rfsd_pair_t gain;
  rfsd_pkg::rfsd_pair_t gain_set;
  logic [1:0] raise;

  assign o_rdata = rdata_ff;
  assign o_reg_code = reg_code_ff;
  assign o_irq = irq_ff;
  assign gain_set.amp = i_amp_channel_gain_setting;
  assign gain_set.phase = i_phase_channel_gain_setting;

  always_comb begin
    if (i_rd) begin
      acc = rfsd_pkg::RFSD_RD;
    end else if (i_wr) begin
      acc = rfsd_pkg::RFSD_WR;
    end else begin
      acc = rfsd_pkg::RFSD_IDLE;
    end
  end

  // latest adjust result, kept until the next adjust completes
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      adj_code_ff <= rfsd_pkg::CODE_ZERO;
    end else if (i_adj_done) begin
      adj_code_ff <= i_adj_code;
    end
  end

  // current limit flag comes from the analog side, so synchronise it
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lim_meta_ff <= 1'b0;
      lim_sync_ff <= 1'b0;
      lim_prev_ff <= 1'b0;
    end else begin
      lim_meta_ff <= i_cur_lim;
      lim_sync_ff <= lim_meta_ff;
      lim_prev_ff <= lim_sync_ff;
    end
  end

  // one tracker per channel: amplitude in slot 1, phase in slot 0
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      logic [rfsd_pkg::CODE_W-1:0] smp;
      logic [rfsd_pkg::CODE_W-1:0] pk;
      logic [rfsd_pkg::CODE_W-1:0] sq;
      logic [rfsd_pkg::CODE_W-1:0] ag;
      logic [rfsd_pkg::CODE_W-1:0] st;
      logic [rfsd_pkg::CODE_W-1:0] tot;
      assign smp = (g == 1) ? i_sample.amp : i_sample.phase;
      assign sq = (g == 1) ? i_squelch_cut.amp : i_squelch_cut.phase;
      assign ag = (g == 1) ? i_agc_cut.amp : i_agc_cut.phase;
      assign st = (g == 1) ? gain_set.amp : gain_set.phase;
      rfsd_peak_hold u_peak (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_start(i_rx_start),
        .i_clr(i_peak_clr),
        .i_vld(i_sample_vld),
        .i_code(smp),
        .o_peak(pk),
        .o_raise(raise[g])
      );
      rfsd_gain_sum u_gain (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_setting(st),
        .i_squelch(sq),
        .i_agc(ag),
        .o_total(tot)
      );
    end
  endgenerate

  assign peak.amp = g_chan[1].pk;
  assign peak.phase = g_chan[0].pk;
  assign gain.amp = g_chan[1].tot;
  assign gain.phase = g_chan[0].tot;

  // control register: source select in bit 7, external code in bits 6:3, all eight bits kept as written
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      reg_ctrl_ff <= rfsd_pkg::RST_BYTE;
    end else if (acc == rfsd_pkg::RFSD_WR && hit(i_addr, rfsd_pkg::OFF_REG_CTRL)) begin
      reg_ctrl_ff <= i_wdata;
    end
  end

  always_comb begin
    if (reg_ctrl_ff[rfsd_pkg::EXT_SEL_BIT]) begin
      nxt_reg_code = reg_ctrl_ff[rfsd_pkg::HI_MSB-1:rfsd_pkg::HI_LSB-1];
    end else begin
      nxt_reg_code = adj_code_ff;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      reg_code_ff <= rfsd_pkg::CODE_ZERO;
    end else begin
      reg_code_ff <= nxt_reg_code;
    end
  end

  // interrupt events
  always_comb begin
    irq_set = rfsd_pkg::IRQ_NONE;
    irq_set[rfsd_pkg::IRQ_ADJ] = i_adj_done;
    irq_set[rfsd_pkg::IRQ_LIM] = lim_sync_ff && !lim_prev_ff;
    irq_set[rfsd_pkg::IRQ_PEAK] = |raise;
  end

  always_comb begin
    irq_clr = rfsd_pkg::IRQ_NONE;
    if (acc == rfsd_pkg::RFSD_WR && hit(i_addr, rfsd_pkg::OFF_IRQ_STAT)) begin
      irq_clr = i_wdata[rfsd_pkg::IRQ_W-1:0];
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_stat_ff <= rfsd_pkg::IRQ_NONE;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_mask_ff <= rfsd_pkg::IRQ_NONE;
    end else if (acc == rfsd_pkg::RFSD_WR && hit(i_addr, rfsd_pkg::OFF_IRQ_MASK)) begin
      irq_mask_ff <= i_wdata[rfsd_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // read mux; display registers have no write path at all
  always_comb begin
    nxt_rdata = rfsd_pkg::RST_BYTE;
    if (acc == rfsd_pkg::RFSD_RD) begin
      if (hit(i_addr, rfsd_pkg::OFF_REG_DISP)) begin
        nxt_rdata[rfsd_pkg::HI_MSB:rfsd_pkg::HI_LSB] = adj_code_ff;
        nxt_rdata[rfsd_pkg::LIM_BIT] = lim_sync_ff;
      end else if (hit(i_addr, rfsd_pkg::OFF_PEAK_DISP)) begin
        nxt_rdata = peak;
      end else if (hit(i_addr, rfsd_pkg::OFF_GAIN_STATE)) begin
        nxt_rdata = gain;
      end else if (hit(i_addr, rfsd_pkg::OFF_REG_CTRL)) begin
        nxt_rdata = reg_ctrl_ff;
      end else if (hit(i_addr, rfsd_pkg::OFF_IRQ_STAT)) begin
        nxt_rdata[rfsd_pkg::IRQ_W-1:0] = irq_stat_ff;
      end else if (hit(i_addr, rfsd_pkg::OFF_IRQ_MASK)) begin
        nxt_rdata[rfsd_pkg::IRQ_W-1:0] = irq_mask_ff;
      end
    end
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_ff <= rfsd_pkg::RST_BYTE;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  a_adj_code_taken: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_adj_done ##1 !i_adj_done
    ##1 (i_rd && hit(i_addr, rfsd_pkg::OFF_REG_DISP) && !i_adj_done)
    |=> o_rdata[7:4] == $past(i_adj_code, 3))
    else $error("regulator display lost the adjust code");

  a_lim_flag_read: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_rd && hit(i_addr, rfsd_pkg::OFF_REG_DISP) |=> o_rdata[0] == $past(lim_sync_ff))
    else $error("current limit flag misread");

  a_lim_sync_delay: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $rose(lim_sync_ff) |-> $past(i_cur_lim, 2))
    else $error("current limit flag rose without input");

  a_amp_peak_read: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_rd && hit(i_addr, rfsd_pkg::OFF_PEAK_DISP) |=> o_rdata[7:4] == $past(peak.amp))
    else $error("amplitude peak misread");

  a_phase_peak_read: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_rd && hit(i_addr, rfsd_pkg::OFF_PEAK_DISP) |=> o_rdata[3:0] == $past(peak.phase))
    else $error("phase peak misread");

  a_amp_gain_read: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_rd && hit(i_addr, rfsd_pkg::OFF_GAIN_STATE) |=> o_rdata[7:4] == $past(gain.amp))
    else $error("amplitude gain cut misread");

  a_phase_gain_read: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_rd && hit(i_addr, rfsd_pkg::OFF_GAIN_STATE) |=> o_rdata[3:0] == $past(gain.phase))
    else $error("phase gain cut misread");

  a_reg_src_select: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ##1 o_reg_code == ($past(reg_ctrl_ff[7]) ? $past(reg_ctrl_ff[6:3]) : $past(adj_code_ff)))
    else $error("regulator code from wrong source");

  a_rsvd_bits_zero: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_rd && hit(i_addr, rfsd_pkg::OFF_REG_DISP) |=> o_rdata[3:1] == 3'h0)
    else $error("reserved bits not zero");

  a_display_write_ignored: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_wr && hit(i_addr, rfsd_pkg::OFF_PEAK_DISP) && !i_adj_done |=> $stable(adj_code_ff)
    && $stable(reg_ctrl_ff) && $stable(irq_mask_ff))
    else $error("display write changed state");

  a_rdata_idle_zero: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !i_rd |=> o_rdata == 8'h00)
    else $error("read data outside the answer cycle");

  a_irq_set_wins: assert property (@(posedge i_clk) disable iff (!i_rstn)
    irq_set[rfsd_pkg::IRQ_ADJ] |=> irq_stat_ff[rfsd_pkg::IRQ_ADJ] ##1 1'b1)
    else $error("status event lost");

  a_irq_level_out: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ##1 o_irq == |($past(irq_stat_ff) & $past(irq_mask_ff)))
    else $error("interrupt level mismatch");

  // event and register bookkeeping
  a_adj_code_load: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_adj_done |=> adj_code_ff == $past(i_adj_code))
    else $error("adjust code not stored");

  a_adj_code_held: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !i_adj_done |=> $stable(adj_code_ff))
    else $error("adjust code changed without an adjust");

  a_lim_flag_clear: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $fell(lim_sync_ff) |-> !$past(i_cur_lim, 2))
    else $error("current limit flag fell without input");

  a_peak_write_kept: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_wr && hit(i_addr, rfsd_pkg::OFF_PEAK_DISP) && !i_rx_start && !i_peak_clr
    && !i_sample_vld |=> $stable(peak))
    else $error("peak display changed by a write");

  a_ctrl_write_taken: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_wr && !i_rd && hit(i_addr, rfsd_pkg::OFF_REG_CTRL) |=> reg_ctrl_ff == $past(i_wdata))
    else $error("control write not taken");

  a_ext_code_out: assert property (@(posedge i_clk) disable iff (!i_rstn)
    reg_ctrl_ff[rfsd_pkg::EXT_SEL_BIT]
    |=> o_reg_code == $past(reg_ctrl_ff[rfsd_pkg::HI_MSB-1:rfsd_pkg::HI_LSB-1]))
    else $error("external regulator code not passed");

  a_mask_write: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_wr && !i_rd && hit(i_addr, rfsd_pkg::OFF_IRQ_MASK)
    |=> irq_mask_ff == $past(i_wdata[rfsd_pkg::IRQ_W-1:0]))
    else $error("mask write not taken");

  a_stat_w1c: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_wr && !i_rd && hit(i_addr, rfsd_pkg::OFF_IRQ_STAT) && irq_set == rfsd_pkg::IRQ_NONE
    |=> (irq_stat_ff & $past(i_wdata[rfsd_pkg::IRQ_W-1:0])) == rfsd_pkg::IRQ_NONE)
    else $error("status bit not cleared by a one");

  a_stat_sticky: assert property (@(posedge i_clk) disable iff (!i_rstn)
    irq_clr == rfsd_pkg::IRQ_NONE
    |=> (irq_stat_ff & $past(irq_stat_ff)) == $past(irq_stat_ff))
    else $error("status bit dropped without a clear");

  a_lim_event: assert property (@(posedge i_clk) disable iff (!i_rstn)
    lim_sync_ff && !lim_prev_ff |=> irq_stat_ff[rfsd_pkg::IRQ_LIM])
    else $error("current limit event lost");

  a_peak_event: assert property (@(posedge i_clk) disable iff (!i_rstn)
    |raise |=> irq_stat_ff[rfsd_pkg::IRQ_PEAK])
    else $error("peak raise event lost");

  c_adjust_then_read: cover property (@(posedge i_clk) disable iff (!i_rstn)
    i_adj_done ##[1:4] (i_rd && hit(i_addr, rfsd_pkg::OFF_REG_DISP)));
  c_peak_rise_clear: cover property (@(posedge i_clk) disable iff (!i_rstn)
    raise[1] ##[1:8] i_peak_clr);
  c_irq_raised: cover property (@(posedge i_clk) disable iff (!i_rstn) $rose(o_irq));
  c_ext_mode: cover property (@(posedge i_clk) disable iff (!i_rstn)
    reg_ctrl_ff[rfsd_pkg::EXT_SEL_BIT] && i_adj_done);
  c_lim_rise: cover property (@(posedge i_clk) disable iff (!i_rstn) $rose(lim_sync_ff));
endmodule : rfsd_top
`default_nettype wire

// [verification/test_rf_receiver_status_display.sv]
// self-checking testbench of the rf receiver status display registers
`timescale 1ns/1ps
`default_nettype none
module test_rf_receiver_status_display;
  logic i_clk;
  logic i_rstn;
  logic [7:0] i_addr;
  logic [7:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [7:0] o_rdata;
  logic i_adj_done;
  logic [3:0] i_adj_code;
  logic i_cur_lim;
  logic i_rx_start;
  logic i_peak_clr;
  logic i_sample_vld;
  rfsd_pkg::rfsd_pair_t i_sample;
  logic [3:0] i_amp_channel_gain_setting;
  logic [3:0] i_phase_channel_gain_setting;
  rfsd_pkg::rfsd_pair_t i_squelch_cut;
  rfsd_pkg::rfsd_pair_t i_agc_cut;
  logic [3:0] o_reg_code;
  logic o_irq;
  int errors;
  int compares;
  // rows: amp setting, squelch, agc, phase setting, squelch, agc, expected byte
  logic [31:0] rows [6] = '{32'h12300060, 32'hF0000FFF, 32'h880555FF, 32'h34120789,
                            32'h095410E5, 32'h00000000};
  logic [7:0] offs [6] = '{rfsd_pkg::OFF_REG_DISP, rfsd_pkg::OFF_PEAK_DISP,
                           rfsd_pkg::OFF_GAIN_STATE, rfsd_pkg::OFF_REG_CTRL,
                           rfsd_pkg::OFF_IRQ_STAT, rfsd_pkg::OFF_IRQ_MASK};

  rfsd_top DUT (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_adj_done(i_adj_done),
    .i_adj_code(i_adj_code), .i_cur_lim(i_cur_lim), .i_rx_start(i_rx_start),
    .i_peak_clr(i_peak_clr), .i_sample_vld(i_sample_vld), .i_sample(i_sample),
    .i_amp_channel_gain_setting(i_amp_channel_gain_setting),
    .i_phase_channel_gain_setting(i_phase_channel_gain_setting),
    .i_squelch_cut(i_squelch_cut), .i_agc_cut(i_agc_cut), .o_reg_code(o_reg_code),
    .o_irq(o_irq));

  always #12.5 i_clk = ~i_clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe, zero after that
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e, "read data");
    @(posedge i_clk);
    #1 chk(o_rdata, 8'h00, "read data idle");
  endtask : rd

  task automatic samp(input logic [7:0] v, input logic st);
    @(posedge i_clk);
    i_sample_vld <= 1'b1;
    i_sample <= v;
    i_rx_start <= st;
    @(posedge i_clk);
    i_sample_vld <= 1'b0;
    i_rx_start <= 1'b0;
  endtask : samp

  task automatic adj(input logic [3:0] c);
    @(posedge i_clk);
    i_adj_done <= 1'b1;
    i_adj_code <= c;
    @(posedge i_clk);
    i_adj_done <= 1'b0;
  endtask : adj

  task automatic irq_is(input logic v);
    repeat (2) @(posedge i_clk);
    #1 chk({7'h00, o_irq}, {7'h00, v}, "interrupt line");
  endtask : irq_is

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // generous bound: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge i_clk);
    errors++;
    end_of_test();
  end

  initial begin
    i_clk = 1'b0; i_rstn = 1'b0; i_addr = 8'h00; i_wdata = 8'h00; i_wr = 1'b0;
    i_rd = 1'b0; i_adj_done = 1'b0; i_adj_code = 4'h0; i_cur_lim = 1'b0;
    i_rx_start = 1'b0; i_peak_clr = 1'b0; i_sample_vld = 1'b0; i_sample = 8'h00;
    i_amp_channel_gain_setting = 4'h0; i_phase_channel_gain_setting = 4'h0;
    i_squelch_cut = 8'h00; i_agc_cut = 8'h00; errors = 0; compares = 0;
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      @(posedge i_clk);
      i_amp_channel_gain_setting <= rows[k][31:28];
      i_squelch_cut <= {rows[k][27:24], rows[k][15:12]};
      i_agc_cut <= {rows[k][23:20], rows[k][11:8]};
      i_phase_channel_gain_setting <= rows[k][19:16];
      rd(rfsd_pkg::OFF_GAIN_STATE, rows[k][7:0]);
    end
    // second reset in mid-run, after some state has been built up
    adj(4'h9);
    wr(rfsd_pkg::OFF_REG_CTRL, 8'hFF);
    @(posedge i_clk);
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1 chk({o_irq, o_reg_code, 3'h0}, 8'h00, "outputs in reset");
    chk(o_rdata, 8'h00, "read data in reset");
    @(posedge i_clk);
    i_rstn <= 1'b1;
    for (int k = 0; k < 6; k++) rd(offs[k], 8'h00);
    // regulator code follows the latest adjust, the mode bit picks the source
    adj(4'hF);
    rd(rfsd_pkg::OFF_REG_DISP, 8'hF0);
    adj(4'h3);
    rd(rfsd_pkg::OFF_REG_DISP, 8'h30);
    chk({4'h0, o_reg_code}, 8'h03, "adjust code selected");
    wr(rfsd_pkg::OFF_REG_CTRL, 8'hA8);
    rd(rfsd_pkg::OFF_REG_CTRL, 8'hA8);
    chk({4'h0, o_reg_code}, 8'h05, "external code selected");
    adj(4'h6);
    rd(rfsd_pkg::OFF_REG_DISP, 8'h60);
    chk({4'h0, o_reg_code}, 8'h05, "external code kept over adjust");
    adj(4'h3);
    wr(rfsd_pkg::OFF_REG_CTRL, 8'h00);
    wr(rfsd_pkg::OFF_REG_DISP, 8'hFF);
    rd(rfsd_pkg::OFF_REG_DISP, 8'h30);
    chk({4'h0, o_reg_code}, 8'h03, "adjust code back");
    // adjust event masked, unmasked, then cleared
    rd(rfsd_pkg::OFF_IRQ_STAT, 8'h01);
    irq_is(1'b0);
    wr(rfsd_pkg::OFF_IRQ_MASK, 8'h01);
    irq_is(1'b1);
    wr(rfsd_pkg::OFF_IRQ_STAT, 8'h01);
    irq_is(1'b0);
    rd(rfsd_pkg::OFF_IRQ_STAT, 8'h00);
    // current limit passes a two-stage synchroniser before it shows
    @(posedge i_clk);
    i_cur_lim <= 1'b1;
    repeat (3) @(posedge i_clk);
    rd(rfsd_pkg::OFF_REG_DISP, 8'h31);
    irq_is(1'b0);
    wr(rfsd_pkg::OFF_IRQ_MASK, 8'h06);
    irq_is(1'b1);
    @(posedge i_clk);
    i_cur_lim <= 1'b0;
    repeat (2) @(posedge i_clk);
    rd(rfsd_pkg::OFF_REG_DISP, 8'h30);
    wr(rfsd_pkg::OFF_IRQ_STAT, 8'h02);
    irq_is(1'b0);
    // peaks: only higher codes load, held until clear or a new reception
    samp(8'h35, 1'b0);
    samp(8'h21, 1'b0);
    rd(rfsd_pkg::OFF_PEAK_DISP, 8'h35);
    samp(8'h72, 1'b0);
    rd(rfsd_pkg::OFF_PEAK_DISP, 8'h75);
    rd(rfsd_pkg::OFF_PEAK_DISP, 8'h75);
    wr(rfsd_pkg::OFF_PEAK_DISP, 8'hFF);
    wr(rfsd_pkg::OFF_GAIN_STATE, 8'hFF);
    rd(rfsd_pkg::OFF_PEAK_DISP, 8'h75);
    rd(rfsd_pkg::OFF_GAIN_STATE, 8'h00);
    rd(rfsd_pkg::OFF_IRQ_STAT, 8'h04);
    irq_is(1'b1);
    wr(rfsd_pkg::OFF_IRQ_STAT, 8'h04);
    irq_is(1'b0);
    @(posedge i_clk);
    i_peak_clr <= 1'b1;
    @(posedge i_clk);
    i_peak_clr <= 1'b0;
    rd(rfsd_pkg::OFF_PEAK_DISP, 8'h00);
    samp(8'hFF, 1'b0);
    rd(rfsd_pkg::OFF_PEAK_DISP, 8'hFF);
    samp(8'h9C, 1'b1);
    rd(rfsd_pkg::OFF_PEAK_DISP, 8'h00);
    // unmapped places read zero and swallow writes
    rd(8'h3F, 8'h00);
    wr(8'h40, 8'h55);
    rd(rfsd_pkg::OFF_REG_CTRL, 8'h00);
    end_of_test();
  end
endmodule : test_rf_receiver_status_display
`default_nettype wire
